// ### hw/cmtpt_pkg.sv
/*
  Package for the compare-match toggle pulse timer: register indices,
  field positions, reset values, codes and timing constants.
  Assumes a 16-bit register port with word-wide access only.
*/
package cmtpt_pkg;

  // Geometry of the timer unit
  localparam int CHANNELS   = 6;
  localparam int CNT_W      = 16;
  localparam int ADDR_W     = 5;

  // Register indices on the plain register port
  localparam logic [4:0] OFS_START     = 5'h00; // Shared start register
  localparam logic [4:0] OFS_CTRL0     = 5'h01; // Channel 0 control
  localparam logic [4:0] OFS_MODE0     = 5'h02; // Channel 0 mode
  localparam logic [4:0] OFS_IOCH0     = 5'h03; // Channel 0 I/O control high
  localparam logic [4:0] OFS_IOCL0     = 5'h04; // Channel 0 I/O control low
  localparam logic [4:0] OFS_CNT0      = 5'h05; // Channel 0 counter
  localparam logic [4:0] OFS_GRA0      = 5'h06; // Channel 0 general A..D
  localparam logic [4:0] OFS_GRB0      = 5'h07;
  localparam logic [4:0] OFS_GRC0      = 5'h08;
  localparam logic [4:0] OFS_GRD0      = 5'h09;
  localparam logic [4:0] OFS_PIN_STAT  = 5'h0A; // Pin level and match status

  // Control register fields
  localparam int COUNTER_CLEAR_SELECT_LSB  = 5;
  localparam int COUNTER_CLEAR_SELECT_W    = 3;
  localparam int TPSC_LSB  = 0;
  localparam int TPSC_W    = 3;
  // I/O control field for output A
  localparam int IOA_LSB   = 0;
  localparam int IOA_W     = 4;
  // Mode register fields
  localparam int MODE_LSB  = 0;
  localparam int MODE_W    = 4;
  localparam int BFA_BIT   = 4;

  // Codes
  localparam logic [2:0] COUNTER_CLEAR_SELECT_NONE  = 3'h0;
  localparam logic [2:0] COUNTER_CLEAR_SELECT_GRA   = 3'h1;
  localparam logic [2:0] TPSC_DIV1  = 3'h0;
  localparam logic [2:0] TPSC_DIV4  = 3'h1;
  localparam logic [2:0] TPSC_DIV16 = 3'h2;
  localparam logic [2:0] TPSC_DIV64 = 3'h3;
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_PWM2   = 4'h3;

  // Reset values
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] GR_RESET  = 16'hFFFF;
  localparam logic [7:0]  REG8_RESET = 8'h00;

  // Timing: peripheral clock period in ns and half-period example count
  localparam int          CLK_NS        = 10;
  localparam logic [15:0] HALF_PERIOD_EX = 16'h00FF;

  // Output action decoded from the I/O control field
  typedef enum logic [1:0] {
    CMTPT_ACT_NONE, CMTPT_ACT_LOW, CMTPT_ACT_HIGH, CMTPT_ACT_TOGGLE
  } cmtpt_act_type;

endpackage

// ### hw/cmtpt_prescaler.sv
/*
  Counter clock divider: turns the select code into a one-cycle enable.
  Assumes one clock; the divider runs freely so all channels share phase.
*/
`timescale 1ns/100ps
module cmtpt_prescaler (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Select and enable
  input  wire logic [2:0]  sel,
  output logic             tick
);
  import cmtpt_pkg::*;

  typedef struct packed {
    logic [5:0] div;
  } cmtpt_div_type;

  cmtpt_div_type s_q, s_d;

  // Free running divide chain
  always_comb begin
    s_d     = s_q;
    s_d.div = s_q.div + 6'h01;
  end

  // Pick the tap; faster codes fire more often
  always_comb begin
    case (sel)
      TPSC_DIV1:  tick = 1'b1;
      TPSC_DIV4:  tick = (s_q.div[1:0] == 2'h3);
      TPSC_DIV16: tick = (s_q.div[3:0] == 4'hF);
      TPSC_DIV64: tick = (s_q.div == 6'h3F);
      default:    tick = 1'b1;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // cmtpt_prescaler

// ### hw/cmtpt_pin_ctrl.sv
/*
  Output pin A action decoder for channel 0.
  Assumes mode and buffer settings are stable while the counter runs.
*/
`timescale 1ns/100ps
module cmtpt_pin_ctrl (
  // Settings
  input  wire logic [3:0]  io_ctrl,
  input  wire logic [3:0]  mode,
  input  wire logic        buf_on,
  // Decoded behaviour
  output logic             init_level,
  output cmtpt_pkg::cmtpt_act_type match_act
);
  import cmtpt_pkg::*;

  // Meaning of the field depends on mode; buffer bit drops the match action but keeps the initial level
  always_comb begin
    init_level = io_ctrl[2];
    match_act  = cmtpt_act_type'(io_ctrl[1:0]);
    if (io_ctrl[3]) begin
      match_act = CMTPT_ACT_NONE; // Capture codes drive nothing
    end
    if (mode == MODE_PWM2) begin
      init_level = io_ctrl[1]; // Stopped level taken from bit 1
    end
    if (buf_on) begin
      match_act = CMTPT_ACT_NONE;
    end
  end

endmodule // cmtpt_pin_ctrl

// ### hw/cmtpt_timer.sv
/*
  Compare-match toggle pulse timer, channel 0 of a six-channel unit with
  start bits for all six. Registers on a plain 16-bit word port.
  Assumes software writes whole words only and stops a channel before
  changing its control or mode register.
*/
// Function
// - Shared start register holds one independent run bit per channel.
// - Stopped channel drives the programmed initial level on its pin.
// - I/O control meaning depends on the mode register.
// - In second PWM mode the setting gives the level at clear; the code instead uses bit 1 only as the stopped level.
// - Buffer use of C and D makes their I/O control inert; the code instead drops pin A's compare-match action.
// - Counter is 16-bit read/write and reset to zero.
// - General registers are 16-bit read/write compare or capture values.
// - Channel 0 has four general registers, A to D.
// - Channel 0 has two I/O control registers.
// - Compare match A clears the counter when clear code selects it.
// - Toggle code inverts pin A at every match.
// - First match drives high, next drives low, alternating.
// - Period is twice the compare value plus two counts.
// - Clear code 001 clears on match with register A.
// - I/O code 0011 makes A a toggling compare, pin starting low.
`timescale 1ns/100ps
module cmtpt_timer (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // Hardware standby clears the counter
  input  wire logic                          standby,
  // Register port
  input  wire logic [cmtpt_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [15:0]                   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [15:0]                   reg_rdata,
  // Pin and capture input
  input  wire logic                          capture_a,
  output logic                               pin_a,
  output logic      [cmtpt_pkg::CHANNELS-1:0] run_bits
);
  import cmtpt_pkg::*;

  typedef struct packed {
    logic [CHANNELS-1:0] start;
    logic [7:0]          ctrl;
    logic [7:0]          mode;
    logic [7:0]          ioch;
    logic [7:0]          iocl;
    logic [15:0]         cnt;
    logic [15:0]         gra;
    logic [15:0]         grb;
    logic [15:0]         grc;
    logic [15:0]         grd;
    logic                match_p;
    logic                pin;
    logic                matched;
    logic [15:0]         rdata;
  } cmtpt_state_type;

  cmtpt_state_type s_q, s_d;
  logic            tick;
  logic            init_level;
  cmtpt_act_type   act;
  logic            running;
  logic            hit;
  logic [15:0]     rd_mux;

  // Shared counter clock divider
  cmtpt_prescaler u_pre (
    .clk   (clk),
    .rst_n (rst_n),
    .sel   (s_q.ctrl[TPSC_LSB +: TPSC_W]),
    .tick  (tick)
  );

  // Pin behaviour follows I/O control as read through the mode
  cmtpt_pin_ctrl u_pin (
    .io_ctrl    (s_q.ioch[IOA_LSB +: IOA_W]),
    .mode       (s_q.mode[MODE_LSB +: MODE_W]),
    .buf_on     (s_q.mode[BFA_BIT]),
    .init_level (init_level),
    .match_act  (act)
  );

  assign running = s_q.start[0];

  // Equality seen on a counter clock; the clear replaces the count past A
  assign hit = running && tick && (s_q.cnt == s_q.gra);

  // Read decode; unmapped indices read as zero
  function automatic logic [15:0] read_word(input cmtpt_state_type s, input logic [ADDR_W-1:0] a);
    case (a)
      OFS_START:    read_word = {10'h000, s.start};
      OFS_CTRL0:    read_word = {8'h00, s.ctrl};
      OFS_MODE0:    read_word = {8'h00, s.mode};
      OFS_IOCH0:    read_word = {8'h00, s.ioch};
      OFS_IOCL0:    read_word = {8'h00, s.iocl};
      OFS_CNT0:     read_word = s.cnt;
      OFS_GRA0:     read_word = s.gra;
      OFS_GRB0:     read_word = s.grb;
      OFS_GRC0:     read_word = s.grc;
      OFS_GRD0:     read_word = s.grd;
      OFS_PIN_STAT: read_word = {14'h0000, s.matched, s.pin};
      default:      read_word = 16'h0000;
    endcase
  endfunction

  assign rd_mux = read_word(s_q, reg_addr);

  // Next-state logic: counting, compare, pin and register writes
  always_comb begin
    s_d         = s_q;
    s_d.match_p = 1'b0;
    s_d.rdata   = reg_rd ? rd_mux : 16'h0000;

    if (hit) begin
      // Counting past A would stretch each half period by one count
      if (s_q.ctrl[COUNTER_CLEAR_SELECT_LSB +: COUNTER_CLEAR_SELECT_W] == COUNTER_CLEAR_SELECT_GRA) begin
          s_d.cnt = CNT_RESET;
        end else begin
          s_d.cnt = s_q.cnt + 16'h0001;
        end
        case (act)
          CMTPT_ACT_LOW:    s_d.pin = 1'b0;
          CMTPT_ACT_HIGH:   s_d.pin = 1'b1;
          CMTPT_ACT_TOGGLE: s_d.pin = ~s_q.pin;
          default:          s_d.pin = s_q.pin;
        endcase
    end else if (running && tick) begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
    // Registered match pulse feeds the sticky status flag
    s_d.match_p = hit;

    // Capture into A when its I/O code selects capture
    if (running && capture_a && s_q.ioch[IOA_LSB + 3]) begin
      s_d.gra = s_q.cnt;
      if (s_q.ctrl[COUNTER_CLEAR_SELECT_LSB +: COUNTER_CLEAR_SELECT_W] == COUNTER_CLEAR_SELECT_GRA) begin
        s_d.cnt = CNT_RESET;
      end
    end

    // Match flag: hardware set wins over a software write to clear
    if (s_q.match_p) begin
      s_d.matched = 1'b1;
    end

    // Stopped channel shows the programmed initial level
    if (!running) begin
      s_d.pin     = init_level;
      s_d.match_p = 1'b0;
    end

    // Register writes, whole words only
    if (reg_wr) begin
      case (reg_addr)
        OFS_START: s_d.start = reg_wdata[CHANNELS-1:0];
        OFS_CTRL0: s_d.ctrl  = reg_wdata[7:0];
        OFS_MODE0: s_d.mode  = reg_wdata[7:0];
        OFS_IOCH0: s_d.ioch  = reg_wdata[7:0];
        OFS_IOCL0: s_d.iocl  = reg_wdata[7:0];
        OFS_CNT0:  s_d.cnt   = reg_wdata;
        OFS_GRA0:  s_d.gra   = reg_wdata;
        OFS_GRB0:  s_d.grb   = reg_wdata;
        OFS_GRC0:  s_d.grc   = reg_wdata;
        OFS_GRD0:  s_d.grd   = reg_wdata;
        OFS_PIN_STAT: begin
          if (reg_wdata[1] && !s_q.match_p) begin
            s_d.matched = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Standby zeroes the counter like a reset
    if (standby) begin
      s_d.cnt     = CNT_RESET;
      s_d.match_p = 1'b0;
    end
  end

  // State register; counter resets to zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q       <= '0;
      s_q.cnt   <= CNT_RESET;
      s_q.gra   <= GR_RESET;
      s_q.grb   <= GR_RESET;
      s_q.grc   <= GR_RESET;
      s_q.grd   <= GR_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign pin_a     = s_q.pin;
  assign run_bits  = s_q.start;

endmodule // cmtpt_timer

// ### sim/cmtpt_chk_asserts.sv
/* Port checker for the pulse timer.
   Assumes a bind to cmtpt_timer and a single clock. */
`timescale 1ns/100ps
module cmtpt_chk (
  // Clock and reset
  input wire logic                            clk,
  input wire logic                            rst_n,
  // Inputs of the timer
  input wire logic                            standby,
  input wire logic [cmtpt_pkg::ADDR_W-1:0]   reg_addr,
  input wire logic [15:0]                     reg_wdata,
  input wire logic                            reg_wr,
  input wire logic                            reg_rd,
  input wire logic                            capture_a,
  // Outputs of the timer
  input wire logic [15:0]                     reg_rdata,
  input wire logic                            pin_a,
  input wire logic [cmtpt_pkg::CHANNELS-1:0] run_bits
);
  import cmtpt_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] quiet_q;

  // Stopped cycles without writes; the pin may settle for a few first
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      quiet_q <= 3'h0;
    else if (reg_wr || run_bits[0])
      quiet_q <= 3'h0;
    else if (quiet_q != 3'h7)
      quiet_q <= quiet_q + 3'h1;

  // Write, then read the same stopped word at once
  property rw_back(logic [4:0] o);
    reg_wr && reg_addr == o && !run_bits[0] && !standby && !capture_a ##1
      reg_rd && reg_addr == o && !standby |=> reg_rdata == $past(reg_wdata, 2);
  endproperty

  a_cnt_rdback: assert property (rw_back(OFS_CNT0))
    else $error("counter read-back differs");
  a_gra_rdback: assert property (rw_back(OFS_GRA0))
    else $error("register A read-back differs");
  a_grb_rdback: assert property (rw_back(OFS_GRB0))
    else $error("register B read-back differs");
  a_grc_rdback: assert property (rw_back(OFS_GRC0))
    else $error("register C read-back differs");
  a_grd_rdback: assert property (rw_back(OFS_GRD0))
    else $error("register D read-back differs");
  a_start_write: assert property (reg_wr && reg_addr == OFS_START |=>
    {10'h000, run_bits} == ($past(reg_wdata) & 16'h003F)) else $error("start bits differ");
  a_stop_hold: assert property (quiet_q >= 3'h4 |-> $stable(pin_a))
    else $error("pin moved while stopped");
  a_standby_zero: assert property ($past(standby) && standby && reg_rd &&
    reg_addr == OFS_CNT0 |=> reg_rdata == 16'h0000) else $error("standby counter not zero");

  c_pin_rise: cover property (run_bits[0] && $rose(pin_a));
  c_standby_rd: cover property (standby && reg_rd);
  c_run_rd: cover property (run_bits[0] && reg_rd && reg_addr == OFS_CNT0);
endmodule // cmtpt_chk

bind cmtpt_timer cmtpt_chk u_cmtpt_chk (
  .clk, .rst_n, .standby, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .capture_a, .reg_rdata, .pin_a, .run_bits
);

// ### sim/cmtpt_pin_mon.sv
/* Watcher for the circuit fed by output pin A.
   Assumes the timer clock; it listens only and drives nothing. */
`timescale 1ns/100ps
module cmtpt_pin_mon (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Watched pin
  input  wire logic        pin_a,
  // Last steady stretch in clocks, and count of changes
  output logic      [15:0] half_q,
  output logic      [15:0] edge_q
);
  logic        last_q;
  logic [15:0] run_q;

  // Each change closes a stretch; its length is half the period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= 1'b0;
      run_q  <= 16'h0001;
      half_q <= 16'h0000;
      edge_q <= 16'h0000;
    end else if (pin_a != last_q) begin
      last_q <= pin_a;
      run_q  <= 16'h0001;
      half_q <= run_q;
      edge_q <= edge_q + 16'h0001;
    end else begin
      run_q <= run_q + 16'h0001;
    end
  end
endmodule // cmtpt_pin_mon

// ### sim/tb_top.sv
/* Testbench for the pulse timer: registers, stopped level, wave, standby.
   Assumes the pin watcher and the bound checker. */
`timescale 1ns/100ps
module tb_top;
  import cmtpt_pkg::*;
  logic                clk, rst_n, standby, capture_a, reg_wr, reg_rd, pin_a, pin_s;
  logic [ADDR_W-1:0]   reg_addr;
  logic [15:0]         reg_wdata, reg_rdata, half_q, edge_q, edge_s, rv;
  logic [CHANNELS-1:0] run_bits;
  int                  miscompares, checked;

  cmtpt_timer u_cmtpt_timer (
    .clk, .rst_n, .standby, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .capture_a, .pin_a, .run_bits
  );
  cmtpt_pin_mon u_cmtpt_pin_mon (.clk, .rst_n, .pin_a, .half_q, .edge_q);

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One bus cycle; snapshots are taken once the last edge has settled
  task automatic op(logic w, logic r, logic [4:0] a, logic [15:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    #1;
    rv = reg_rdata;
    pin_s = pin_a;
    edge_s = edge_q;
    @(posedge clk);
  endtask

  task automatic idle(int n);
    repeat (n) op(1'b0, 1'b0, OFS_START, 16'h0000);
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(string n, logic [4:0] a, logic [15:0] e);
    op(1'b0, 1'b1, a, 16'h0000);
    op(1'b0, 1'b0, a, 16'h0000);
    check(n, rv, e);
  endtask

  task automatic finish_test();
    $display("Counts: %0d checked, %0d miscompares", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Bounded wait for the next pin change; a hang ends the run
  task automatic wait_edge();
    logic [15:0] n0;
    n0 = edge_s;
    for (int k = 0; k < 700 && edge_s == n0; k++)
      idle(1);
    if (edge_s == n0) begin
      miscompares++;
      $display("MISMATCH pin edge expected change seen none");
      finish_test();
    end
  endtask

  task automatic t_regs();
    rd_chk("start", OFS_START, 16'h0000);
    rd_chk("counter", OFS_CNT0, CNT_RESET);
    rd_chk("gra", OFS_GRA0, GR_RESET);
    for (int i = 0; i < 4; i++) begin
      op(1'b1, 1'b0, OFS_GRA0 + 5'(i), 16'hA5C0 + 16'(i));
      rd_chk("gr", OFS_GRA0 + 5'(i), 16'hA5C0 + 16'(i));
    end
    op(1'b1, 1'b0, OFS_CNT0, 16'h1234);
    rd_chk("counter", OFS_CNT0, 16'h1234);
    op(1'b1, 1'b0, OFS_START, 16'h002A);
    rd_chk("start", OFS_START, 16'h002A);
    op(1'b1, 1'b0, 5'h1F, 16'hFFFF);
    rd_chk("unmapped", 5'h1F, 16'h0000);
    op(1'b1, 1'b0, OFS_START, 16'h0000);
    $display("t_regs done");
  endtask

  // Stopped pin shows the programmed initial level
  task automatic t_stop();
    op(1'b1, 1'b0, OFS_CTRL0, 16'h0020);
    op(1'b1, 1'b0, OFS_IOCH0, 16'h0007);
    idle(4);
    check("init high", {15'h0, pin_s}, 16'h0001);
    op(1'b1, 1'b0, OFS_IOCH0, 16'h0003);
    idle(4);
    check("init low", {15'h0, pin_s}, 16'h0000);
    $display("t_stop done");
  endtask

  // Toggle wave: first level high, half length A+1, back to rest on stop
  task automatic t_wave(logic [15:0] half);
    op(1'b1, 1'b0, OFS_CNT0, 16'h0000);
    op(1'b1, 1'b0, OFS_GRA0, half);
    op(1'b1, 1'b0, OFS_START, 16'h0001);
    wait_edge();
    check("first level", {15'h0, pin_s}, 16'h0001);
    wait_edge();
    check("second level", {15'h0, pin_s}, 16'h0000);
    wait_edge();
    check("half length", half_q, half + 16'h0001);
    op(1'b0, 1'b1, OFS_CNT0, 16'h0000);
    idle(1);
    check("counter bound", {15'h0, rv > half}, 16'h0000);
    op(1'b1, 1'b0, OFS_START, 16'h0000);
    idle(4);
    check("stopped level", {15'h0, pin_s}, 16'h0000);
    rd_chk("match flag", OFS_PIN_STAT, 16'h0002);
    op(1'b1, 1'b0, OFS_PIN_STAT, 16'h0002);
    rd_chk("flag cleared", OFS_PIN_STAT, 16'h0000);
    $display("t_wave done");
  endtask

  // Mode changes what I/O control means; buffer mode silences pin A
  task automatic t_modes();
    op(1'b1, 1'b0, OFS_MODE0, 16'h0003);
    op(1'b1, 1'b0, OFS_IOCH0, 16'h0005);
    idle(4);
    check("pwm2 init", {15'h0, pin_s}, 16'h0000);
    op(1'b1, 1'b0, OFS_MODE0, 16'h0000);
    idle(4);
    check("normal init", {15'h0, pin_s}, 16'h0001);
    op(1'b1, 1'b0, OFS_IOCH0, 16'h0003);
    op(1'b1, 1'b0, OFS_MODE0, 16'h0010);
    op(1'b1, 1'b0, OFS_START, 16'h0001);
    idle(40);
    check("buffer pin", {15'h0, pin_s}, 16'h0000);
    rd_chk("buffer match", OFS_PIN_STAT, 16'h0002);
    op(1'b1, 1'b0, OFS_START, 16'h0000);
    op(1'b1, 1'b0, OFS_MODE0, 16'h0000);
    idle(4);
    $display("t_modes done");
  endtask

  // Standby zeroes a running counter
  task automatic t_standby();
    op(1'b1, 1'b0, OFS_START, 16'h0001);
    idle(20);
    standby <= 1'b1;
    idle(2);
    rd_chk("standby counter", OFS_CNT0, CNT_RESET);
    standby <= 1'b0;
    op(1'b1, 1'b0, OFS_START, 16'h0000);
    idle(1);
    $display("t_standby done");
  endtask

  initial begin
    rst_n = 1'b0;
    standby = 1'b0;
    capture_a = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = 16'h0000;
    miscompares = 0;
    checked = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_stop();
    t_wave(HALF_PERIOD_EX);
    t_wave(16'h0003);
    t_modes();
    t_standby();
    finish_test();
  end
endmodule // tb_top
